// file: ocs_pkg.sv
// Constants, register map and state encodings for the output shutdown/enable control
// What this block does
// - Pin is shutdown input when function bit set
// - Polarity select lives in pin control bit 1
// - Asserted pin in shutdown mode forces global shutdown
// - Global shutdown tri-states outputs, power stays on
// - Synthesizer and dividers keep running in shutdown
// - Enable mode: polarity 0 high, 1 low
// - Active pin forces static off unless enable low
// - Inactive pin with enable low keeps output running
// - Disable bit low always forces high impedance
// - Pin function bit resets cleared, shutdown off
// - Status bit 7 reports store burned
// - Burning only clears bits, never sets them
// - Four separately burned slots, each flagged
// - Unburned slot reads back all ones
// - Host reaches registers over the I2C link
package ocs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OTP_STATUS_ADDR = 8'h00; // Store status
   localparam logic [7:0] PIN_CTRL_ADDR = 8'h10; // Pin function and polarity
   localparam logic [7:0] OUT_EN_N_ADDR = 8'h11; // Per-output active-low enables
   localparam logic [7:0] OUT_DIS_N_ADDR = 8'h12; // Per-output disable bits
   localparam logic [7:0] OTP_CMD_ADDR = 8'h13; // Slot select, burn, load
   localparam logic [7:0] OTP_RD0_ADDR = 8'h14; // Slot readback byte 0
   localparam logic [7:0] OTP_RD1_ADDR = 8'h15; // Slot readback byte 1
   localparam logic [7:0] OTP_RD2_ADDR = 8'h16; // Slot readback byte 2

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int PIN_FUNC_BIT = 0; // 1 = shutdown, 0 = output enable
   localparam int PIN_POL_BIT = 1; // 1 = enable pin active low
   localparam int STAT_BURNED_BIT = 7; // Any slot burned
   localparam int CMD_BURN_BIT = 4; // Write 1 to burn selected slot
   localparam int CMD_LOAD_BIT = 5; // Write 1 to load selected slot

   // ------------------------------------------------------------
   // Reset values and sizes
   // ------------------------------------------------------------
   localparam logic [7:0] PIN_CTRL_RST = 8'h00; // Shutdown disabled
   localparam logic [7:0] OUT_EN_N_RST = 8'h00; // All outputs enabled
   localparam logic [7:0] OUT_DIS_N_RST = 8'hff; // No output forced off
   localparam logic [7:0] BYTE_ONES = 8'hff; // Erased store byte
   localparam logic [3:0] BYTE_BITS = 4'h8; // Bits per I2C byte
   localparam int OTP_SLOTS = 4; // Stored configurations
   localparam int OTP_BYTES = 3; // Bytes kept per configuration

   // ------------------------------------------------------------
   // I2C slave states
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_WR = 3'b011,
      ST_RD = 3'b100,
      ST_RACK = 3'b101
   } ocs_state_e;

endpackage

// file: ocs_sync.sv
// Two-flop synchroniser for the dual-function pin
`timescale 1ns/1ns
module ocs_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_reg; // First stage, read only by second
   logic [W-1:0] sync_reg; // Second stage

   // ------------------------------------------------------------
   // Two stages so no gate ever sees a metastable level
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule // ocs_sync

// file: ocs_otp.sv
// One-time-programmable configuration store with per-slot burned flags
`timescale 1ns/1ns
module ocs_otp #(
   parameter int SLOTS = ocs_pkg::OTP_SLOTS,
   parameter int DW = ocs_pkg::OTP_BYTES * 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Burn port
   input wire logic burn_i,
   input wire logic [1:0] slot_i,
   input wire logic [DW-1:0] data_i,
   // Read port
   output logic [DW-1:0] rd_data_o,
   output logic [SLOTS-1:0] burned_o
);

   logic [DW-1:0] mem_reg [SLOTS]; // Fuse array, only meaningful once burned
   logic [DW-1:0] mem_next [SLOTS];
   logic [SLOTS-1:0] fresh_reg = '1; // Slot flag fuses, 1 = never burned; a blank part
   logic [SLOTS-1:0] fresh_next;

   // ------------------------------------------------------------
   // Burn: fuses can only go from one to zero
   // ------------------------------------------------------------
   always_comb
   begin
      mem_next = mem_reg;
      fresh_next = fresh_reg;
      // Burns are ignored while the part is held in reset
      if (burn_i && rst_b_i)
      begin
         // A blank slot starts from all ones
         mem_next[slot_i] = (fresh_reg[slot_i] ? {DW{1'b1}} : mem_reg[slot_i]) & data_i;
         fresh_next[slot_i] = 1'b0;
      end
   end

   // No reset: fuses keep their state through a power cycle
   always_ff @(posedge clk_i)
   begin
      mem_reg <= mem_next;
      fresh_reg <= fresh_next;
   end

   // Unburned slots read their erased ones
   assign rd_data_o = fresh_reg[slot_i] ? {DW{1'b1}} : mem_reg[slot_i];
   assign burned_o = ~fresh_reg;

endmodule // ocs_otp

// file: ocs_output_ctrl.sv
// Top: I2C register slave, output state decision and configuration store control
`timescale 1ns/1ns
module ocs_output_ctrl #(
   parameter int NUM_OUT = 5,
   parameter logic [6:0] DEV_ADDR = 7'h2c // Arbitrary bus address
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // I2C link, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Dual-function pin
   input wire logic shutdown_or_enable_pin_i,
   // Per-output driver state
   output logic [NUM_OUT-1:0] out_run_o,
   output logic [NUM_OUT-1:0] out_off_o,
   output logic [NUM_OUT-1:0] out_hiz_o,
   output logic [NUM_OUT-1:0] out_off_level_o,
   // Synthesizer and divider run
   output logic synth_run_o
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int DW = ocs_pkg::OTP_BYTES * 8;

   // Link sampling
   logic scl_q_reg; // Previous clock level
   logic sda_q_reg; // Previous data level
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Slave state
   ocs_pkg::ocs_state_e st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next; // Bits seen in this byte
   logic [7:0] shift_reg, shift_next; // Receive / transmit byte
   logic [7:0] ptr_reg, ptr_next; // Register pointer
   logic rw_reg, rw_next; // 1 = host reads
   logic first_reg, first_next; // Next written byte is pointer
   logic oe_reg, oe_next; // Pull data low
   logic wr_en; // Register write strobe

   // Software registers
   logic func_reg, func_next; // pin_function_select
   logic pol_reg, pol_next; // pin_polarity_select
   logic [NUM_OUT-1:0] en_n_reg, en_n_next; // Active-low enables
   logic [NUM_OUT-1:0] dis_n_reg, dis_n_next; // per_output_disable_n
   logic [1:0] slot_reg, slot_next; // Selected store slot
   logic burn_reg, burn_next; // One-cycle burn pulse
   logic load_reg, load_next; // One-cycle load pulse

   // Store and pin
   logic [DW-1:0] otp_rd;
   logic [DW-1:0] otp_wr;
   logic [ocs_pkg::OTP_SLOTS-1:0] otp_burned;
   logic pin_sync;

   // Output decision
   logic [NUM_OUT-1:0] run_next, off_next, hiz_next, lvl_next;
   logic [NUM_OUT-1:0] run_reg, off_reg, hiz_reg, lvl_reg;
   logic shutdown_now; // Global shutdown in force
   logic enable_pin_active; // Enable-mode pin asserted

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   // Pin is resynchronised so outputs never see a runt
   ocs_sync #(
      .W(1)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i(shutdown_or_enable_pin_i),
      .q_o(pin_sync)
   );

   ocs_otp #(
      .SLOTS(ocs_pkg::OTP_SLOTS),
      .DW(DW)
   ) u_otp (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .burn_i(burn_reg),
      .slot_i(slot_reg),
      .data_i(otp_wr),
      .rd_data_o(otp_rd),
      .burned_o(otp_burned)
   );

   // Snapshot of live settings that a burn stores
   assign otp_wr = {8'(dis_n_reg), 8'(en_n_reg), 6'h00, pol_reg, func_reg};

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         ocs_pkg::OTP_STATUS_ADDR:
         begin
            d[ocs_pkg::STAT_BURNED_BIT] = |otp_burned;
            d[ocs_pkg::OTP_SLOTS-1:0] = otp_burned;
         end
         ocs_pkg::PIN_CTRL_ADDR:
         begin
            d[ocs_pkg::PIN_FUNC_BIT] = func_reg;
            d[ocs_pkg::PIN_POL_BIT] = pol_reg;
         end
         ocs_pkg::OUT_EN_N_ADDR: d = 8'(en_n_reg);
         ocs_pkg::OUT_DIS_N_ADDR: d = 8'(dis_n_reg);
         ocs_pkg::OTP_CMD_ADDR: d = 8'(slot_reg);
         ocs_pkg::OTP_RD0_ADDR: d = otp_rd[7:0];
         ocs_pkg::OTP_RD1_ADDR: d = otp_rd[15:8];
         ocs_pkg::OTP_RD2_ADDR: d = otp_rd[23:16];
         default: d = 8'h00; // Unmapped reads zero
      endcase
      return d;
   endfunction

   // ------------------------------------------------------------
   // Link edge and condition detection
   // ------------------------------------------------------------
   assign scl_rise = scl_i & ~scl_q_reg;
   assign scl_fall = ~scl_i & scl_q_reg;
   assign start_seen = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
   assign stop_seen = scl_i & scl_q_reg & ~sda_q_reg & sda_i;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end
      else
      begin
         scl_q_reg <= scl_i;
         sda_q_reg <= sda_i;
      end
   end

   // ------------------------------------------------------------
   // I2C slave state machine
   // ------------------------------------------------------------
   // Data changes only after a falling clock, so setup is a full low phase
   always_comb
   begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      first_next = first_reg;
      oe_next = oe_reg;
      wr_en = 1'b0;
      if (start_seen)
      begin
         // Start or repeated start
         st_next = ocs_pkg::ST_ADDR;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end
      else if (stop_seen)
      begin
         st_next = ocs_pkg::ST_IDLE;
         oe_next = 1'b0;
      end
      else
      begin
         case (st_reg)
            ocs_pkg::ST_IDLE:
            begin
               oe_next = 1'b0;
            end
            ocs_pkg::ST_ADDR, ocs_pkg::ST_WR:
            begin
               if (scl_rise && cnt_reg < ocs_pkg::BYTE_BITS)
               begin
                  shift_next = {shift_reg[6:0], sda_i};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (scl_fall && cnt_reg == ocs_pkg::BYTE_BITS)
               begin
                  if (st_reg == ocs_pkg::ST_ADDR)
                  begin
                     // Only our own address is acknowledged
                     if (shift_reg[7:1] == DEV_ADDR)
                     begin
                        rw_next = shift_reg[0];
                        first_next = 1'b1;
                        oe_next = 1'b1;
                        st_next = ocs_pkg::ST_ACK;
                     end
                     else
                     begin
                        st_next = ocs_pkg::ST_IDLE;
                     end
                  end
                  else
                  begin
                     if (first_reg)
                     begin
                        ptr_next = shift_reg;
                        first_next = 1'b0;
                     end
                     else
                     begin
                        wr_en = 1'b1;
                        ptr_next = ptr_reg + 8'h01;
                     end
                     oe_next = 1'b1;
                     st_next = ocs_pkg::ST_ACK;
                  end
               end
            end
            ocs_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_next = 4'h0;
                  if (rw_reg)
                  begin
                     // Load next read byte, present its top bit
                     shift_next = reg_read(ptr_reg);
                     oe_next = ~shift_next[7];
                     ptr_next = ptr_reg + 8'h01;
                     st_next = ocs_pkg::ST_RD;
                  end
                  else
                  begin
                     oe_next = 1'b0;
                     st_next = ocs_pkg::ST_WR;
                  end
               end
            end
            ocs_pkg::ST_RD:
            begin
               if (scl_rise)
               begin
                  cnt_next = cnt_reg + 4'h1;
               end
               if (scl_fall)
               begin
                  if (cnt_reg == ocs_pkg::BYTE_BITS)
                  begin
                     oe_next = 1'b0; // Free the line for host ack
                     st_next = ocs_pkg::ST_RACK;
                  end
                  else
                  begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next = ~shift_reg[6];
                  end
               end
            end
            ocs_pkg::ST_RACK:
            begin
               if (scl_rise)
               begin
                  // Nack ends the read; ack reuses the load path
                  st_next = sda_i ? ocs_pkg::ST_IDLE : ocs_pkg::ST_ACK;
               end
            end
            default:
            begin
               st_next = ocs_pkg::ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg <= ocs_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         first_reg <= first_next;
         oe_reg <= oe_next;
      end
   end

   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_reg;

   // ------------------------------------------------------------
   // Software register file
   // ------------------------------------------------------------
   // A load from the store takes priority over a same-cycle write
   always_comb
   begin
      func_next = func_reg;
      pol_next = pol_reg;
      en_n_next = en_n_reg;
      dis_n_next = dis_n_reg;
      slot_next = slot_reg;
      burn_next = 1'b0;
      load_next = 1'b0;
      if (load_reg)
      begin
         func_next = otp_rd[ocs_pkg::PIN_FUNC_BIT];
         pol_next = otp_rd[ocs_pkg::PIN_POL_BIT];
         en_n_next = otp_rd[8 +: NUM_OUT];
         dis_n_next = otp_rd[16 +: NUM_OUT];
      end
      else if (wr_en)
      begin
         case (ptr_reg)
            ocs_pkg::PIN_CTRL_ADDR:
            begin
               func_next = shift_reg[ocs_pkg::PIN_FUNC_BIT];
               pol_next = shift_reg[ocs_pkg::PIN_POL_BIT];
            end
            ocs_pkg::OUT_EN_N_ADDR: en_n_next = shift_reg[NUM_OUT-1:0];
            ocs_pkg::OUT_DIS_N_ADDR: dis_n_next = shift_reg[NUM_OUT-1:0];
            ocs_pkg::OTP_CMD_ADDR:
            begin
               slot_next = shift_reg[1:0];
               burn_next = shift_reg[ocs_pkg::CMD_BURN_BIT];
               load_next = shift_reg[ocs_pkg::CMD_LOAD_BIT];
            end
            default: ; // Status and readback are read-only
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         func_reg <= ocs_pkg::PIN_CTRL_RST[ocs_pkg::PIN_FUNC_BIT];
         pol_reg <= ocs_pkg::PIN_CTRL_RST[ocs_pkg::PIN_POL_BIT];
         en_n_reg <= ocs_pkg::OUT_EN_N_RST[NUM_OUT-1:0];
         dis_n_reg <= ocs_pkg::OUT_DIS_N_RST[NUM_OUT-1:0];
         slot_reg <= 2'h0;
         burn_reg <= 1'b0;
         load_reg <= 1'b0;
      end
      else
      begin
         func_reg <= func_next;
         pol_reg <= pol_next;
         en_n_reg <= en_n_next;
         dis_n_reg <= dis_n_next;
         slot_reg <= slot_next;
         burn_reg <= burn_next;
         load_reg <= load_next;
      end
   end

   // ------------------------------------------------------------
   // Output state decision
   // ------------------------------------------------------------
   // Shutdown pin is active high; polarity only applies in enable mode
   assign shutdown_now = func_reg & pin_sync;
   assign enable_pin_active = ~func_reg & (pin_sync ^ pol_reg);

   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
         run_next[i] = 1'b1;
         off_next[i] = 1'b0;
         hiz_next[i] = 1'b0;
         // Single-ended reference rests high, others rest low
         lvl_next[i] = (i == 0);
         if (!dis_n_reg[i] || shutdown_now)
         begin
            run_next[i] = 1'b0;
            hiz_next[i] = 1'b1;
         end
         else if (enable_pin_active && en_n_reg[i])
         begin
            run_next[i] = 1'b0;
            off_next[i] = 1'b1;
         end
         // Otherwise a low enable keeps the output running
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         run_reg <= '0;
         off_reg <= '0;
         hiz_reg <= '1;
         lvl_reg <= '0;
      end
      else
      begin
         run_reg <= run_next;
         off_reg <= off_next;
         hiz_reg <= hiz_next;
         lvl_reg <= lvl_next;
      end
   end

   assign out_run_o = run_reg;
   assign out_off_o = off_reg;
   assign out_hiz_o = hiz_reg;
   assign out_off_level_o = lvl_reg;

   // Shutdown touches only drivers; synthesis never stops
   assign synth_run_o = 1'b1;

endmodule // ocs_output_ctrl

// file: ocs_props.sv
// Port-level checker for the output control block
`timescale 1ns/1ns
module ocs_props #(
   parameter int NUM_OUT = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Watched ports
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic shutdown_or_enable_pin_i,
   input wire logic [NUM_OUT-1:0] out_run_o,
   input wire logic [NUM_OUT-1:0] out_off_o,
   input wire logic [NUM_OUT-1:0] out_hiz_o,
   input wire logic [NUM_OUT-1:0] out_off_level_o,
   input wire logic synth_run_o
);
   // ----------
   // Helpers
   // ----------
   localparam logic [NUM_OUT-1:0] ALL = {NUM_OUT{1'b1}}; // Every output
   localparam logic [NUM_OUT-1:0] LVL0 = {{(NUM_OUT-1){1'b0}}, 1'b1}; // Only reference high
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Ack or data bit held for a whole phase
   sequence s_oe_held;
      sda_oe_o [*3];
   endsequence
   // Line let go within a read byte
   sequence s_oe_gone;
      ##[1:200] !sda_oe_o;
   endsequence
   // ----------
   // Assertions
   // ----------
   a_one_state: assert property ((out_run_o ^ out_off_o ^ out_hiz_o) == ALL
      && (out_run_o & out_off_o & out_hiz_o) == '0) else $error("output state not unique");
   a_synth_on: assert property (synth_run_o) else $error("synthesizer stopped");
   a_sda_open: assert property (sda_o == 1'b0) else $error("data driven high");
   a_off_level: assert property ($past(rst_b_i) |-> out_off_level_o == LVL0) else $error("off level");
   // Two sync flops mean two quiet edges first
   a_pin_synced: assert property ($changed(shutdown_or_enable_pin_i) |=>
      $stable({out_run_o, out_off_o, out_hiz_o}) [*2]) else $error("pin used unsynchronised");
   a_ack_hold: assert property ($rose(sda_oe_o) |-> s_oe_held) else $error("ack too short");
   a_ack_bound: assert property ($rose(sda_oe_o) |-> s_oe_gone) else $error("data line stuck");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("data changed with clock high");
   a_reset_exit: assert property ($rose(rst_b_i) |-> out_hiz_o == ALL ##1 out_run_o == ALL)
      else $error("reset state wrong");
endmodule // ocs_props

bind ocs_output_ctrl ocs_props #(.NUM_OUT(NUM_OUT)) props_u (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .scl_i(scl_i),
   .sda_o(sda_o),
   .sda_oe_o(sda_oe_o),
   .shutdown_or_enable_pin_i(shutdown_or_enable_pin_i),
   .out_run_o(out_run_o),
   .out_off_o(out_off_o),
   .out_hiz_o(out_hiz_o),
   .out_off_level_o(out_off_level_o),
   .synth_run_o(synth_run_o)
);

// file: ocs_host.sv
// Board-level I2C host model
`timescale 1ns/1ns
module ocs_host (
   // Clock
   input wire logic clk_i,
   // Resolved data wire
   input wire logic sda_i,
   // Host drive, 1 lets the pull-up win
   output logic scl_o,
   output logic sda_o
);
   // Idle bus
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Wait n falling edges, host moves only there
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // One bit, phases of 4 cycles to clear the 3-cycle minimum
   task automatic bit_io(input logic d, output logic q);
      scl_o = 1'b0;
      wt(2);
      sda_o = d;
      wt(2);
      scl_o = 1'b1;
      wt(2);
      q = sda_i;
      wt(2);
   endtask
   // Start or repeated start
   task automatic start();
      logic q;
      bit_io(1'b1, q);
      sda_o = 1'b0;
      wt(4);
   endtask
   // Stop
   task automatic stop();
      logic q;
      bit_io(1'b0, q);
      sda_o = 1'b1;
      wt(4);
   endtask
   // Byte MSB first, then ack bit sent as mack
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ak);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(mack, ak);
   endtask
endmodule // ocs_host

// file: tb_top.sv
// Self-checking bench for the output control block
`timescale 1ns/1ns
module tb_top;
   // ----------
   // Signals
   // ----------
   localparam logic [6:0] DEV = 7'h2c; // Arbitrary bus address
   logic clk = 1'b0; // 250 MHz
   logic rst_b = 1'b0; // Reset, active low
   logic pin = 1'b0; // Dual-function pin
   logic scl; // Host clock
   logic sda_h; // Host drive
   logic sda_o; // Always low
   logic sda_oe; // Device pull
   logic [4:0] run, off, hiz, lvl; // Output states
   logic synth; // Synthesizer run
   wire sda_w; // Pulled-up wire
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0; // Timeout count
   assign sda_w = sda_h & ~sda_oe;
   always #2 clk = ~clk;
   ocs_host host_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
   ocs_output_ctrl #(.NUM_OUT(5), .DEV_ADDR(DEV)) dut_u (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .shutdown_or_enable_pin_i(pin), .out_run_o(run),
      .out_off_o(off), .out_hiz_o(hiz), .out_off_level_o(lvl), .synth_run_o(synth));
   // ----------
   // Tasks
   // ----------
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic [2:0] k;
      host_u.start();
      host_u.xfer({DEV, 1'b0}, 1'b1, r, k[2]);
      host_u.xfer(a, 1'b1, r, k[1]);
      host_u.xfer(d, 1'b1, r, k[0]);
      host_u.stop();
      chk({12'h000, k}, 15'h0000);
   endtask
   // Read one register, nack ends it
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic [7:0] v;
      logic [2:0] k;
      host_u.start();
      host_u.xfer({DEV, 1'b0}, 1'b1, r, k[2]);
      host_u.xfer(a, 1'b1, r, k[1]);
      host_u.start();
      host_u.xfer({DEV, 1'b1}, 1'b1, r, k[0]);
      host_u.xfer(8'hff, 1'b1, v, r[0]);
      host_u.stop();
      chk({4'h0, k, v}, {7'h00, e});
   endtask
   // Outputs after the 3-edge pin lag
   task automatic oc(input logic [4:0] r, input logic [4:0] o, input logic [4:0] h);
      repeat (4) @(negedge clk);
      chk({run, off, hiz}, {r, o, h});
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Hang guard, run needs about 6800 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   // ----------
   // Main sequence
   // ----------
   initial
   begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      oc(5'h1f, 5'h00, 5'h00);
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h40, 8'h00);
      wr(8'h11, 8'h1a);
      oc(5'h1f, 5'h00, 5'h00);
      pin = 1'b1;
      oc(5'h05, 5'h1a, 5'h00);
      chk({10'h000, lvl}, 15'h0001);
      wr(8'h10, 8'h02);
      oc(5'h1f, 5'h00, 5'h00);
      pin = 1'b0;
      oc(5'h05, 5'h1a, 5'h00);
      wr(8'h12, 8'h1d);
      oc(5'h05, 5'h18, 5'h02);
      wr(8'h10, 8'h01);
      oc(5'h1d, 5'h00, 5'h02);
      pin = 1'b1;
      oc(5'h00, 5'h00, 5'h1f);
      chk({13'h0000, sda_o, synth}, 15'h0001);
      pin = 1'b0;
      wr(8'h13, 8'h01);
      rd_chk(8'h14, 8'hff);
      wr(8'h13, 8'h11);
      // Power cycle before readback; burned fuses must survive it
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      oc(5'h1f, 5'h00, 5'h00);
      wr(8'h13, 8'h01);
      rd_chk(8'h00, 8'h82);
      rd_chk(8'h14, 8'h01);
      rd_chk(8'h15, 8'h1a);
      rd_chk(8'h16, 8'h1d);
      wr(8'h00, 8'h00);
      rd_chk(8'h00, 8'h82);
      wr(8'h10, 8'h02);
      wr(8'h13, 8'h11);
      rd_chk(8'h14, 8'h00);
      wr(8'h13, 8'h00);
      rd_chk(8'h14, 8'hff);
      wr(8'h13, 8'h21);
      rd_chk(8'h10, 8'h00);
      end_of_test();
   end
endmodule // tb_top
